// >>> ext_bus_pkg.sv
// Purpose: Shared constants and types for the external bus interface.
// Assumes: One input clock at four times the system rate.
// Notes: Bus vectors are numbered most significant line first.
package ext_bus_pkg;

  // Bus widths
  localparam int ADDR_W = 14;
  localparam int DATA_W = 8;
  localparam int KIND_W = 2;

  // Input clocks per system cycle, and phase counter points
  localparam int PHASES = 4;
  localparam logic [1:0] PHASE_LAST = 2'h3;
  localparam logic [1:0] PHASE_BEFORE_STROBE = 2'h1;
  localparam logic [1:0] PHASE_BEFORE_THIRD = 2'h1;
  localparam logic [1:0] PHASE_RESET = 2'h0;

  // Lowest address line index in the [0:13] numbering
  localparam int LOW_LINE = 13;

  // Reset values of pin registers
  localparam logic [0:ADDR_W-1] ADDR_RESET = 14'h0000;
  localparam logic [0:DATA_W-1] DATA_RESET = 8'h00;

  // Request kinds carried through the buffer
  typedef enum logic [KIND_W-1:0] {
    KIND_MEM_READ,
    KIND_MEM_WRITE,
    KIND_SERIAL_OUT,
    KIND_EXT_INSTR
  } req_kind_t;

  // Packed request width: kind, address, write data, serial or code bit
  localparam int REQ_W = KIND_W + ADDR_W + DATA_W + 1;

endpackage : ext_bus_pkg

// >>> req_buffer.sv
// Purpose: Two-entry request buffer with valid and ready on both sides.
// Assumes: Synchronous active-high reset.
// Notes: Full and empty are exact; a stalled drain side backs up to the source.
`timescale 1ns/1ps
`default_nettype none

module req_buffer #(
  parameter int WIDTH = 25,
  parameter int DEPTH = 2
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr, next_wr_ptr;
  logic [PTR_W-1:0] rd_ptr, next_rd_ptr;
  logic [CNT_W-1:0] count, next_count;
  logic push, pop;

  // Pointer step with wrap at the depth
  function automatic logic [PTR_W-1:0] step(input logic [PTR_W-1:0] p);
    step = (p == PTR_W'(DEPTH - 1)) ? '0 : p + PTR_W'(1);
  endfunction : step

  ////////////////////////////////////////////////////////////////////////
  // Handshake and next pointers
  always_comb begin
    in_ready = (count != CNT_W'(DEPTH));
    out_valid = (count != '0);
    out_data = mem[rd_ptr];
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    next_wr_ptr = push ? step(wr_ptr) : wr_ptr;
    next_rd_ptr = pop ? step(rd_ptr) : rd_ptr;
    next_count = count + CNT_W'(push) - CNT_W'(pop);
  end

  // Pointer registers
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  // Storage, no reset needed
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

endmodule : req_buffer

`default_nettype wire

// >>> ext_bus_if.sv
// Purpose: External memory, serial I/O and hold pins of a small processor.
// Assumes: clock is the input clock at four times the system cycle rate.
// Notes: Three-state pins are split into out and an active-low enable; the data bus also has an in.
`timescale 1ns/1ps
`default_nettype none

// Function
// - The fourteen address lines, MSB first, carry the memory address while memory select is low.
// - With memory select high the address lines carry serial bit and external instruction addresses.
// - Every address line floats while hold is granted.
// - Serial output requests put their data bit on the lowest address line.
// - External instruction requests put one code bit on the lowest address line.
// - The data bus is eight bidirectional three-state lines with line zero as MSB.
// - During memory cycles the data bus carries write data out and read data in.
// - All data lines float while hold is granted.
// - An inverted copy of the third internal clock phase is driven out.
// - The read direction output is high while the data outputs are off for a memory read.
// - The read direction output is low otherwise and floats while hold is granted.
// - Memory select is active low, marks a memory address and floats during hold.
// - Hold granted is active high and marks that all bus and memory control outputs float.
module ext_bus_if
  import ext_bus_pkg::*;
#(
  parameter int BUF_DEPTH = 2
) (
  input wire logic clock,
  input wire logic sys_rst,
  // Request stream
  input wire logic req_valid,
  output logic req_ready,
  input wire ext_bus_pkg::req_kind_t req_kind,
  input wire logic [0:ext_bus_pkg::ADDR_W-1] req_addr,
  input wire logic [0:ext_bus_pkg::DATA_W-1] req_wdata,
  input wire logic req_bit,
  // Read answer
  output logic rsp_valid,
  output logic [0:ext_bus_pkg::DATA_W-1] rsp_data,
  // Hold
  input wire logic hold_request,
  output logic hold_granted,
  // Address bus
  output logic [0:ext_bus_pkg::ADDR_W-1] address_out,
  output logic address_oe_n,
  // Data bus
  output logic [0:ext_bus_pkg::DATA_W-1] data_out,
  input wire logic [0:ext_bus_pkg::DATA_W-1] data_in,
  output logic data_oe_n,
  // Control pins
  output logic memory_cycle_select_n,
  output logic memory_cycle_select_oe_n,
  output logic read_direction,
  output logic read_direction_oe_n,
  output logic serial_io_strobe,
  output logic phase3_n
);

  import ext_bus_pkg::*;

  typedef enum {
    ST_IDLE,
    ST_READ,
    ST_WRITE,
    ST_SERIAL,
    ST_HOLD
  } bus_state_t;

  bus_state_t state, next_state;
  logic [1:0] phase, next_phase;
  logic [0:ADDR_W-1] next_address_out;
  logic [0:DATA_W-1] next_data_out;
  logic [0:DATA_W-1] next_rsp_data;
  logic next_address_oe_n, next_data_oe_n, next_hold_granted;
  logic next_mcs_n, next_mcs_oe_n, next_read_direction, next_rd_oe_n;
  logic next_strobe, next_phase3_n, next_rsp_valid;
  logic cur_bit, next_cur_bit;
  logic cycle_end;
  logic buf_valid, buf_ready;
  logic [REQ_W-1:0] buf_data;
  req_kind_t buf_kind;
  logic [0:ADDR_W-1] buf_addr;
  logic [0:DATA_W-1] buf_wdata;
  logic buf_bit;

  ////////////////////////////////////////////////////////////////////////
  // Request buffer, drained only at a system cycle boundary
  req_buffer #(
    .WIDTH(REQ_W),
    .DEPTH(BUF_DEPTH)
  ) u_req_buffer (
    .clock(clock),
    .sys_rst(sys_rst),
    .in_valid(req_valid),
    .in_ready(req_ready),
    .in_data({req_kind, req_addr, req_wdata, req_bit}),
    .out_valid(buf_valid),
    .out_ready(buf_ready),
    .out_data(buf_data)
  );

  // Unpack the head entry
  assign buf_kind = req_kind_t'(buf_data[REQ_W-1 -: KIND_W]);
  assign {buf_addr, buf_wdata, buf_bit} = buf_data[REQ_W-KIND_W-1:0];

  ////////////////////////////////////////////////////////////////////////
  // Phase divider and cycle sequencing
  always_comb begin
    cycle_end = (phase == PHASE_LAST);
    next_phase = phase + 2'h1; // Divide by four
    next_phase3_n = !(phase == PHASE_BEFORE_THIRD); // Low during phase three
    next_state = state;
    next_cur_bit = cur_bit;
    next_address_out = address_out;
    next_data_out = data_out;
    next_rsp_data = rsp_data;
    next_rsp_valid = 1'b0;
    buf_ready = 1'b0;
    // Read data taken at the end of the read cycle
    if (state == ST_READ && cycle_end) begin
      next_rsp_data = data_in;
      next_rsp_valid = 1'b1;
    end
    // New bus cycle chosen only at a boundary; a running cycle always completes
    if (cycle_end) begin
      if (hold_request) begin
        next_state = ST_HOLD;
      end else if (buf_valid) begin
        buf_ready = 1'b1;
        next_address_out = buf_addr;
        next_cur_bit = buf_bit;
        case (buf_kind)
          KIND_MEM_READ: begin
            next_state = ST_READ;
          end
          KIND_MEM_WRITE: begin
            next_state = ST_WRITE;
            next_data_out = buf_wdata;
          end
          KIND_SERIAL_OUT: begin
            next_state = ST_SERIAL;
            next_address_out[LOW_LINE] = buf_bit; // Serial data bit
          end
          KIND_EXT_INSTR: begin
            next_state = ST_SERIAL;
            next_address_out[LOW_LINE] = buf_bit; // External code bit
          end
          default: begin
            next_state = ST_IDLE;
          end
        endcase
      end else begin
        next_state = ST_IDLE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin controls derived from the coming state
  always_comb begin
    next_hold_granted = 1'b0;
    next_address_oe_n = 1'b0;
    next_data_oe_n = 1'b1;
    next_mcs_n = 1'b1;
    next_mcs_oe_n = 1'b0;
    next_read_direction = 1'b0; // Low in all other cases
    next_rd_oe_n = 1'b0;
    next_strobe = 1'b0;
    case (next_state)
      ST_HOLD: begin
        // All bus and memory control outputs float while hold is granted
        next_hold_granted = 1'b1;
        next_address_oe_n = 1'b1;
        next_mcs_oe_n = 1'b1;
        next_rd_oe_n = 1'b1;
      end
      ST_READ: begin
        next_mcs_n = 1'b0;
        next_read_direction = 1'b1; // Outputs off, memory drives
      end
      ST_WRITE: begin
        next_mcs_n = 1'b0;
        next_data_oe_n = 1'b0; // Drive write data
      end
      ST_SERIAL: begin
        // Strobe high in phase three, mid-cycle after the bit settles
        next_strobe = (state == ST_SERIAL) && (phase == PHASE_BEFORE_STROBE);
      end
      ST_IDLE: begin
        next_mcs_n = 1'b1;
      end
      default: begin
        next_hold_granted = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // State and pin registers
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      phase <= PHASE_RESET;
      cur_bit <= 1'b0;
      address_out <= ADDR_RESET;
      data_out <= DATA_RESET;
      rsp_data <= DATA_RESET;
      rsp_valid <= 1'b0;
      hold_granted <= 1'b0;
      address_oe_n <= 1'b0;
      data_oe_n <= 1'b1;
      memory_cycle_select_n <= 1'b1;
      memory_cycle_select_oe_n <= 1'b0;
      read_direction <= 1'b0;
      read_direction_oe_n <= 1'b0;
      serial_io_strobe <= 1'b0;
      phase3_n <= 1'b1;
    end else begin
      state <= next_state;
      phase <= next_phase;
      cur_bit <= next_cur_bit;
      address_out <= next_address_out;
      data_out <= next_data_out;
      rsp_data <= next_rsp_data;
      rsp_valid <= next_rsp_valid;
      hold_granted <= next_hold_granted;
      address_oe_n <= next_address_oe_n;
      data_oe_n <= next_data_oe_n;
      memory_cycle_select_n <= next_mcs_n;
      memory_cycle_select_oe_n <= next_mcs_oe_n;
      read_direction <= next_read_direction;
      read_direction_oe_n <= next_rd_oe_n;
      serial_io_strobe <= next_strobe;
      phase3_n <= next_phase3_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  hold_float_a: assert property (
    hold_granted |-> (address_oe_n && data_oe_n && memory_cycle_select_oe_n
                      && read_direction_oe_n))
    else $error("bus pin driven during hold");

  mem_addr_a: assert property (
    !memory_cycle_select_n |-> (!address_oe_n && !memory_cycle_select_oe_n && !hold_granted))
    else $error("memory select without driven address");

  rd_buffers_a: assert property (
    read_direction |-> (data_oe_n && !memory_cycle_select_n))
    else $error("read direction high with data driven");

  rd_low_a: assert property (
    (state != ST_READ && !hold_granted) |-> (!read_direction && !read_direction_oe_n))
    else $error("read direction not low outside reads");

  strobe_io_a: assert property (
    serial_io_strobe |-> (memory_cycle_select_n && !address_oe_n))
    else $error("strobe during a memory cycle");

  serial_bit_a: assert property (
    serial_io_strobe |-> (address_out[LOW_LINE] == cur_bit && $stable(address_out)))
    else $error("lowest line not stable at strobe");

  phase_div_a: assert property (
    $fell(phase3_n) |=> phase3_n [*3] ##1 !phase3_n)
    else $error("third phase not one in four");

  write_drive_a: assert property (
    !data_oe_n |-> (!memory_cycle_select_n && state == ST_WRITE && !read_direction))
    else $error("data driven outside a write");

  read_sample_a: assert property (
    (state == ST_READ && phase == PHASE_LAST) |=> (rsp_valid && rsp_data == $past(data_in)))
    else $error("read data not returned");

  hold_wait_a: assert property (
    (hold_request && phase == PHASE_LAST) |=> hold_granted)
    else $error("hold not granted at boundary");

  read_c: cover property (state == ST_READ ##4 rsp_valid);
  write_c: cover property (!data_oe_n);
  strobe_c: cover property ($rose(serial_io_strobe));
  hold_c: cover property ($rose(hold_granted) ##[1:20] $fell(hold_granted));

endmodule : ext_bus_if

`default_nettype wire

// >>> mem_partner.sv
// Purpose: Memory and serial I/O logic at the far side of the bus.
// Assumes: Sixteen bytes decoded from the lowest four address lines.
// Notes: A released data bus shows the inverse of its last level.
`timescale 1ns/1ps
`default_nettype none
module mem_partner
  import ext_bus_pkg::*;
(
  input wire logic clock,
  input wire logic [0:ext_bus_pkg::ADDR_W-1] address_out,
  input wire logic address_oe_n,
  input wire logic [0:ext_bus_pkg::DATA_W-1] data_out,
  input wire logic data_oe_n,
  input wire logic memory_cycle_select_n,
  input wire logic read_direction,
  input wire logic serial_io_strobe,
  output logic [0:ext_bus_pkg::DATA_W-1] data_in,
  output logic serial_bit
);
  logic [0:DATA_W-1] mem [16];
  logic [0:DATA_W-1] last = 8'h00;
  logic selected;
  ////////////////////////////////////////////////////////////////////////////
  // Memory cycle decode
  assign selected = !memory_cycle_select_n && !address_oe_n;
  // Read data, else a pattern that moves every cycle
  assign data_in = (selected && read_direction && data_oe_n) ?
    mem[address_out[10:13]] : ~last;
  // Write capture and bus history
  always_ff @(posedge clock) begin
    last <= data_in;
    if (selected && !data_oe_n) begin
      mem[address_out[10:13]] <= data_out;
    end
  end
  // Serial bit taken on the rising strobe
  always_ff @(posedge serial_io_strobe) begin
    serial_bit <= address_out[LOW_LINE];
  end
endmodule : mem_partner
`default_nettype wire

// >>> tb.sv
// Purpose: Self-checking bench for the external bus interface.
// Assumes: Inputs driven and outputs sampled at the falling edge.
// Notes: Table rows first, then phase and hold cases by hand.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ext_bus_pkg::*;
  typedef struct packed {
    req_kind_t kind;
    logic [0:13] addr;
    logic [0:7] wdata;
    logic sbit;
    logic [0:7] exp;
  } row_t;
  row_t rows [7] = '{'{KIND_MEM_WRITE, 14'h0005, 8'hA5, 1'b0, 8'hA5},
    '{KIND_MEM_READ, 14'h0005, 8'h00, 1'b0, 8'hA5},
    '{KIND_MEM_WRITE, 14'h3FFA, 8'h3C, 1'b0, 8'h3C},
    '{KIND_MEM_READ, 14'h3FFA, 8'h00, 1'b0, 8'h3C},
    '{KIND_SERIAL_OUT, 14'h2AAB, 8'h00, 1'b0, 8'h00},
    '{KIND_SERIAL_OUT, 14'h1554, 8'h00, 1'b1, 8'h00},
    '{KIND_EXT_INSTR, 14'h0003, 8'h00, 1'b0, 8'h00}};
  logic clock, sys_rst, req_valid, req_ready, req_bit, rsp_valid, hold_request, hold_granted;
  req_kind_t req_kind;
  logic [0:ADDR_W-1] req_addr, address_out;
  logic [0:DATA_W-1] req_wdata, rsp_data, data_out, data_in;
  logic address_oe_n, data_oe_n, memory_cycle_select_n, memory_cycle_select_oe_n;
  logic read_direction, read_direction_oe_n, serial_io_strobe, phase3_n, serial_bit;
  int err_count = 0;
  int n_tests = 0;
  int n;
  ext_bus_if ext_bus_if_i (.clock(clock), .sys_rst(sys_rst), .req_valid(req_valid),
    .req_ready(req_ready), .req_kind(req_kind), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_bit(req_bit), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .hold_request(hold_request), .hold_granted(hold_granted), .address_out(address_out),
    .address_oe_n(address_oe_n), .data_out(data_out), .data_in(data_in),
    .data_oe_n(data_oe_n), .memory_cycle_select_n(memory_cycle_select_n),
    .memory_cycle_select_oe_n(memory_cycle_select_oe_n), .read_direction(read_direction),
    .read_direction_oe_n(read_direction_oe_n), .serial_io_strobe(serial_io_strobe),
    .phase3_n(phase3_n));
  mem_partner mem_partner_i (.clock(clock), .address_out(address_out),
    .address_oe_n(address_oe_n), .data_out(data_out), .data_oe_n(data_oe_n),
    .memory_cycle_select_n(memory_cycle_select_n), .read_direction(read_direction),
    .serial_io_strobe(serial_io_strobe), .data_in(data_in), .serial_bit(serial_bit));
  ////////////////////////////////////////////////////////////////////////////
  // Input clock at four times the system rate
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // Verdict and end of run
  task automatic conclude();
    if (err_count == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  // One comparison
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // Bounded wait for an output to reach a level
  task automatic wait_for(input int sel, input logic v);
    logic s;
    for (int i = 0; i < 60; i++) begin
      @(negedge clock);
      case (sel)
        0: s = rsp_valid;
        1: s = hold_granted;
        2: s = serial_io_strobe;
        3: s = read_direction;
        default: s = data_oe_n;
      endcase
      if (s === v) return;
    end
    err_count++;
    $display("[FAIL] t=%0t got=%h exp=%h", $time, ~v, v);
    conclude();
  endtask : wait_for
  // Offer one request, held until taken
  task automatic send(input row_t r);
    int i;
    @(negedge clock);
    req_valid = 1'b1;
    req_kind = r.kind;
    req_addr = r.addr;
    req_wdata = r.wdata;
    req_bit = r.sbit;
    for (i = 0; i < 60 && req_ready !== 1'b1; i++) @(negedge clock);
    if (i == 60) begin
      check(16'h0, 16'h1);
      conclude();
    end
    @(negedge clock);
    req_valid = 1'b0;
  endtask : send
  // Main sequence
  initial begin
    sys_rst = 1'b1;
    req_valid = 1'b0;
    req_kind = KIND_MEM_READ;
    req_addr = 14'h0000;
    req_wdata = 8'h00;
    req_bit = 1'b0;
    hold_request = 1'b0;
    repeat (3) @(negedge clock);
    sys_rst = 1'b0;
    check({hold_granted, memory_cycle_select_n, read_direction}, 16'h2);
    // Table rows, one bus cycle each
    foreach (rows[k]) begin
      send(rows[k]);
      case (rows[k].kind)
        KIND_MEM_READ: begin
          wait_for(3, 1'b1);
          check(address_out, rows[k].addr);
          check({memory_cycle_select_n, data_oe_n}, 16'h1);
          wait_for(0, 1'b1);
          check(rsp_data, rows[k].exp);
        end
        KIND_MEM_WRITE: begin
          wait_for(4, 1'b0);
          check(address_out, rows[k].addr);
          check({memory_cycle_select_n, read_direction}, 16'h0);
          check(data_out, rows[k].exp);
        end
        default: begin
          wait_for(2, 1'b1);
          check(address_out[0:12], rows[k].addr[0:12]);
          check({memory_cycle_select_n, address_out[13]}, {1'b1, rows[k].sbit});
          check(serial_bit, rows[k].sbit);
        end
      endcase
    end
    // One low phase output in every four input clocks
    n = 0;
    repeat (16) begin
      @(negedge clock);
      if (phase3_n === 1'b0) n++;
    end
    check(16'(n), 16'h4);
    // Hold floats the bus while the buffer fills
    hold_request = 1'b1;
    wait_for(1, 1'b1);
    send(rows[1]);
    send(rows[3]);
    check({address_oe_n, data_oe_n}, 16'h3);
    check({memory_cycle_select_oe_n, read_direction_oe_n, req_ready}, 16'h6);
    hold_request = 1'b0;
    wait_for(0, 1'b1);
    check(rsp_data, 16'hA5);
    wait_for(0, 1'b1);
    check(rsp_data, 16'h3C);
    check({hold_granted, address_oe_n, memory_cycle_select_oe_n}, 16'h0);
    // Reset in mid-run returns every pin to its idle level
    sys_rst = 1'b1;
    repeat (3) @(negedge clock);
    check({address_oe_n, data_oe_n, memory_cycle_select_n, read_direction, phase3_n,
      serial_io_strobe, rsp_valid, hold_granted, req_ready}, 16'hD1);
    check(address_out, 16'h0);
    sys_rst = 1'b0;
    // Requests are taken again after the release
    send(rows[3]);
    wait_for(0, 1'b1);
    check(rsp_data, 16'h3C);
    conclude();
  end
endmodule : tb
`default_nettype wire
